/* spi_ctrl_pkg.sv */
// constants, state encodings and register map of the serial control block
package spi_ctrl_pkg;

   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_CTRL_ONE = 10'h000;
   localparam logic [9:0] IDX_CTRL_TWO = 10'h001;
   localparam logic [9:0] IDX_STATUS   = 10'h003;
   localparam logic [9:0] IDX_DATA_HI  = 10'h004;
   localparam logic [9:0] IDX_DATA_LO  = 10'h005;
   localparam logic [9:0] IDX_MASK     = 10'h008;

   // first control register fields
   localparam int BIT_MODULE_EN = 6;
   localparam int BIT_MASTER    = 4;
   localparam int BIT_SS_OUT_EN = 1;
   localparam logic [7:0] CTRL_ONE_BITS = 8'h52;

   // second control register fields
   localparam int BIT_XFER_WIDTH = 6;
   localparam int BIT_FAULT_EN   = 4;
   localparam int BIT_BIDIR_OE   = 3;
   localparam int BIT_WAIT_STOP  = 1;
   localparam int BIT_PIN_CTRL   = 0;
   localparam logic [7:0] CTRL_TWO_BITS = 8'h5b;

   // status and mask layout
   localparam int BIT_DONE  = 7;
   localparam int BIT_FAULT = 4;
   localparam logic [7:0] STATUS_BITS = 8'h90;

   localparam logic [7:0] CTRL_RESET = 8'h00;

   // frame lengths in bits
   localparam logic [4:0] FRAME_NARROW = 5'h08;
   localparam logic [4:0] FRAME_WIDE   = 5'h10;

   // bus clocks per half period of the generated serial clock
   localparam int HALF_PERIOD_CYCLES = 4;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_XFER = 2'b10
   } xfer_state_e;

endpackage

/* sync_two.sv */
// two-stage synchroniser for a group of pin levels
`timescale 1ns/100ps
module sync_two #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

/* spi_width_pin_ctrl.sv */
// serial port with width selection, fault detection and pin configuration
`timescale 1ns/100ps
module spi_width_pin_ctrl
   import spi_ctrl_pkg::*;
#(
   parameter int HALF_CNT = HALF_PERIOD_CYCLES
) (
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // serial pins
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe,
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe,
   input  wire logic        ss_n_i,
   output logic             ss_n_o,
   output logic             ss_n_oe,
   // system
   input  wire logic        wait_mode,
   output logic             irq
);

   typedef struct packed {
      xfer_state_e st;
      logic [7:0]  ctrl1;
      logic [7:0]  ctrl2;
      logic [7:0]  stat;
      logic [7:0]  mask;
      logic [7:0]  tx_hi;
      logic [7:0]  tx_lo;
      logic [15:0] shreg;
      logic [15:0] rx;
      logic [4:0]  bitcnt;
      logic [7:0]  div;
      logic        sck_prev;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        sck_o;
      logic        sck_oe;
      logic        mosi_o;
      logic        mosi_oe;
      logic        miso_o;
      logic        miso_oe;
      logic        ss_n_o;
      logic        ss_n_oe;
      logic        irq;
   } state_s;

   state_s r_r;
   state_s r_nxt;

   logic [4:0] pins_s;
   logic       sck_s, ss_n_s, mosi_s, miso_s, wait_s;

   sync_two #(.WIDTH(5)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .async_in({sck_i, ss_n_i, mosi_i, miso_i, wait_mode}),
      .sync_out(pins_s)
   );
   assign {sck_s, ss_n_s, mosi_s, miso_s, wait_s} = pins_s;

   function automatic logic unmapped(input logic [9:0] idx);
      unmapped = !(idx == IDX_CTRL_ONE || idx == IDX_CTRL_TWO || idx == IDX_STATUS ||
                   idx == IDX_DATA_HI || idx == IDX_DATA_LO || idx == IDX_MASK);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic       en, master, wide, fden, bidir, oe2, ssoe, wstop;
   logic [9:0] idx;
   logic       wr_fire, rd_phase;
   logic [7:0] wbyte, ctrl2_new;
   logic       abort, tick, din, dout, fault_ev, done_ev, last_bit;
   logic [4:0] frame_len;

   always_comb begin
      r_nxt     = r_r;
      en        = r_r.ctrl1[BIT_MODULE_EN];
      master    = r_r.ctrl1[BIT_MASTER];
      ssoe      = r_r.ctrl1[BIT_SS_OUT_EN];
      wide      = r_r.ctrl2[BIT_XFER_WIDTH];
      fden      = r_r.ctrl2[BIT_FAULT_EN];
      oe2       = r_r.ctrl2[BIT_BIDIR_OE];
      bidir     = r_r.ctrl2[BIT_PIN_CTRL];
      wstop     = r_r.ctrl2[BIT_WAIT_STOP];
      idx       = paddr[11:2];
      wbyte     = pwdata[7:0];
      rd_phase  = psel && penable && !r_r.pready;
      wr_fire   = psel && penable && r_r.pready && pwrite && !r_r.pslverr;
      ctrl2_new = wbyte & CTRL_TWO_BITS;
      frame_len = wide ? FRAME_WIDE : FRAME_NARROW;
      last_bit  = (r_r.bitcnt == frame_len - 5'h01);
      abort     = 1'b0;
      fault_ev  = 1'b0;
      done_ev   = 1'b0;
      tick      = 1'b0;

      // one wait state: answer registered, write lands on the completing edge
      r_nxt.pready  = rd_phase;
      r_nxt.pslverr = rd_phase && unmapped(idx);
      if (rd_phase) begin
         r_nxt.prdata = 32'h0000_0000;
         unique case (idx)
            IDX_CTRL_ONE: r_nxt.prdata[7:0] = r_r.ctrl1;
            IDX_CTRL_TWO: r_nxt.prdata[7:0] = r_r.ctrl2;
            IDX_STATUS:   r_nxt.prdata[7:0] = r_r.stat;
            IDX_DATA_HI:  r_nxt.prdata[7:0] = wide ? r_r.rx[15:8] : 8'h00;
            IDX_DATA_LO:  r_nxt.prdata[7:0] = r_r.rx[7:0];
            IDX_MASK:     r_nxt.prdata[7:0] = r_r.mask;
            default:      r_nxt.prdata[7:0] = 8'h00;
         endcase
      end

      // register writes
      if (wr_fire) begin
         unique case (idx)
            IDX_CTRL_ONE: begin
               r_nxt.ctrl1 = wbyte & CTRL_ONE_BITS;
               if (master && (wbyte[BIT_MASTER] != master))
                  abort = 1'b1;
            end
            IDX_CTRL_TWO: begin
               r_nxt.ctrl2 = ctrl2_new;
               if (master && ((ctrl2_new[BIT_XFER_WIDTH] != wide) ||
                              (ctrl2_new[BIT_FAULT_EN] != fden) ||
                              (ctrl2_new[BIT_PIN_CTRL] != bidir)))
                  abort = 1'b1;
               if (master && bidir && (ctrl2_new[BIT_BIDIR_OE] != oe2))
                  abort = 1'b1;
            end
            IDX_DATA_HI:  r_nxt.tx_hi = wbyte;
            IDX_DATA_LO:  r_nxt.tx_lo = wbyte;
            IDX_MASK:     r_nxt.mask  = wbyte & STATUS_BITS;
            default:      r_nxt.tx_lo = r_r.tx_lo;
         endcase
      end

      // select pin is only a fault input when master, fault on, no ss drive
      if (en && master && fden && !ssoe && !ss_n_s) begin
         fault_ev = 1'b1;
         abort    = 1'b1;
      end

      // received data pin per pin configuration
      if (master)
         din = bidir ? mosi_s : miso_s;
      else
         din = bidir ? miso_s : mosi_s;
      dout = wide ? r_r.shreg[15] : r_r.shreg[7];

      // baud divider, frozen in wait mode when clock stop is set
      if (r_r.st == ST_XFER && master && !(wstop && wait_s)) begin
         if (r_r.div == 8'(HALF_CNT - 1)) begin
            r_nxt.div = 8'h00;
            tick      = 1'b1;
         end else begin
            r_nxt.div = r_r.div + 8'h01;
         end
      end
      r_nxt.sck_prev = sck_s;

      unique case (r_r.st)
         ST_IDLE: begin
            r_nxt.bitcnt = 5'h00;
            r_nxt.div    = 8'h00;
            r_nxt.sck_o  = 1'b0;
            if (en && master && wr_fire && idx == IDX_DATA_LO && !abort) begin
               r_nxt.shreg = wide ? {r_r.tx_hi, wbyte} : {8'h00, wbyte};
               r_nxt.st    = ST_XFER;
            end else if (en && !master && !ss_n_s) begin
               r_nxt.shreg = wide ? {r_r.tx_hi, r_r.tx_lo} : {8'h00, r_r.tx_lo};
               r_nxt.st    = ST_XFER;
            end
         end
         ST_XFER: begin
            if (master) begin
               if (tick && !r_r.sck_o) begin
                  r_nxt.sck_o = 1'b1;
                  r_nxt.shreg = {r_r.shreg[14:0], din};
               end else if (tick) begin
                  r_nxt.sck_o  = 1'b0;
                  r_nxt.bitcnt = r_r.bitcnt + 5'h01;
                  done_ev      = last_bit;
               end
            end else if (ss_n_s) begin
               r_nxt.st = ST_IDLE;
            end else if (sck_s && !r_r.sck_prev) begin
               r_nxt.shreg  = {r_r.shreg[14:0], din};
               r_nxt.bitcnt = r_r.bitcnt + 5'h01;
               done_ev      = last_bit;
            end
            if (done_ev) begin
               r_nxt.rx = wide ? r_nxt.shreg : {8'h00, r_nxt.shreg[7:0]};
               r_nxt.st = master ? ST_IDLE : ST_XFER;
               r_nxt.bitcnt = 5'h00;
            end
         end
      endcase

      // set wins over write-one-to-clear
      if (wr_fire && idx == IDX_STATUS)
         r_nxt.stat = r_r.stat & ~wbyte;
      if (done_ev)
         r_nxt.stat[BIT_DONE] = 1'b1;
      if (fault_ev)
         r_nxt.stat[BIT_FAULT] = 1'b1;

      if (abort || !r_nxt.ctrl1[BIT_MODULE_EN]) begin
         r_nxt.st     = ST_IDLE;
         r_nxt.bitcnt = 5'h00;
         r_nxt.sck_o  = 1'b0;
      end
      if (!r_nxt.ctrl1[BIT_MODULE_EN])
         r_nxt.stat = 8'h00;

      // pin drivers, registered
      r_nxt.sck_oe  = en && master;
      r_nxt.mosi_o  = dout;
      r_nxt.miso_o  = dout;
      r_nxt.mosi_oe = en && master && (!bidir || oe2);
      r_nxt.miso_oe = en && !master && !ss_n_s && (!bidir || oe2);
      // slave never drives select; master only with fault and ss output on
      r_nxt.ss_n_oe = en && master && fden && ssoe;
      r_nxt.ss_n_o  = !(r_r.st == ST_XFER);
      r_nxt.irq     = |(r_nxt.stat & r_nxt.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r       <= '0;
         r_r.st    <= ST_IDLE;
         r_r.ctrl1 <= CTRL_RESET;
         r_r.ctrl2 <= CTRL_RESET;
         r_r.ss_n_o <= 1'b1;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign prdata  = r_r.prdata;
   assign pready  = r_r.pready;
   assign pslverr = r_r.pslverr;
   assign sck_o   = r_r.sck_o;
   assign sck_oe  = r_r.sck_oe;
   assign mosi_o  = r_r.mosi_o;
   assign mosi_oe = r_r.mosi_oe;
   assign miso_o  = r_r.miso_o;
   assign miso_oe = r_r.miso_oe;
   assign ss_n_o  = r_r.ss_n_o;
   assign ss_n_oe = r_r.ss_n_oe;
   assign irq     = r_r.irq;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_reserved_zero: assert property ((r_r.ctrl2 & ~CTRL_TWO_BITS) == 8'h00)
      else $error("reserved control bits not zero");
   a_width_abort: assert property (wr_fire && idx == IDX_CTRL_TWO && master &&
         (ctrl2_new[BIT_XFER_WIDTH] != wide) |=> r_r.st == ST_IDLE)
      else $error("width change did not abort");
   a_oe_abort: assert property (wr_fire && idx == IDX_CTRL_TWO && master && bidir &&
         (ctrl2_new[BIT_BIDIR_OE] != oe2) |=> r_r.st == ST_IDLE && r_r.bitcnt == 5'h00)
      else $error("output enable change did not abort");
   a_mosi_gate: assert property (r_r.mosi_oe |-> $past(master) &&
         (!$past(bidir) || $past(oe2)))
      else $error("mosi driven in wrong mode");
   a_miso_gate: assert property (r_r.miso_oe |-> !$past(master) &&
         (!$past(bidir) || $past(oe2)))
      else $error("miso driven in wrong mode");
   a_ss_unused: assert property (master && !fden ##1 1'b1 |-> !r_r.ss_n_oe)
      else $error("select pin driven without fault enable");
   a_slave_ss_in: assert property (!master ##1 !master |-> !r_r.ss_n_oe)
      else $error("slave drove select pin");
   a_fault_flag: assert property (en && master && fden && !ssoe && !ss_n_s &&
         r_nxt.ctrl1[BIT_MODULE_EN] |=> r_r.stat[BIT_FAULT] && r_r.st == ST_IDLE)
      else $error("mode fault not flagged");
   a_disable_idle: assert property (!en ##1 !en |-> r_r.st == ST_IDLE &&
         r_r.stat == 8'h00)
      else $error("disabled block not idle");
   a_wait_hold: assert property (master && wstop && wait_s &&
         r_r.st == ST_XFER |=> r_r.sck_o == $past(r_r.sck_o))
      else $error("serial clock ran in wait mode");
   a_frame_len: assert property (r_r.bitcnt < frame_len ||
         $past(r_r.ctrl2[BIT_XFER_WIDTH]) != wide)
      else $error("bit count beyond frame length");

   c_wide_done: cover property (wide && done_ev);
   c_narrow_done: cover property (!wide && done_ev && master);
   c_fault: cover property (fault_ev);
   c_bidir_xfer: cover property (bidir && r_r.st == ST_XFER && r_r.mosi_oe);
endmodule

/* spi_far_end.sv */
// far-side serial device model: slave to a master port, master to a slave port
`timescale 1ns/100ps
module spi_far_end (
   // board wires
   input  wire logic sck_w,
   input  wire logic mosi_w,
   input  wire logic miso_w,
   // far-side drivers
   output logic      sck_d,
   output logic      mosi_d,
   output logic      miso_d,
   output logic      ss_d
);
   logic [15:0] tx_r;
   logic [15:0] rx_r;
   int          n_r;

   initial begin
      sck_d = 1'b0;
      mosi_d = 1'b0;
      miso_d = 1'b0;
      ss_d = 1'b1;
      tx_r = 16'h0000;
      rx_r = 16'h0000;
      n_r = 8;
   end

   task automatic load(input logic [15:0] tx, input int n);
      tx_r = tx;
      n_r = n;
      miso_d = tx[n-1];
   endtask

   task automatic select(input logic v);
      ss_d = v;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // slave role: sample on rise, next bit after fall
   always @(posedge sck_w) rx_r = {rx_r[14:0], mosi_w};
   // for n_r bits past the frame the line shows inverted bits, not a stale copy
   always @(negedge sck_w) begin
      tx_r = {tx_r[14:0], ~tx_r[n_r-1]};
      miso_d = tx_r[n_r-1];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // master role: clock stands still outside the frame
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      // keep every link edge clear of the bus clock edge
      #5;
      ss_d = 1'b0;
      #160;
      for (int i = n - 1; i >= 0; i--) begin
         mosi_d = tx[i];
         #80 sck_d = 1'b1;
         rx = {rx[14:0], miso_w};
         #80 sck_d = 1'b0;
      end
      mosi_d = ~mosi_d;
      #160 ss_d = 1'b1;
   endtask
endmodule

/* spi_width_pin_ctrl_tb.sv */
// self-checking bench for the serial width and pin control block
`timescale 1ns/100ps
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
   $display("BAD %s exp %h got %h", nm, e, s); end end
module spi_width_pin_ctrl_tb;
   import spi_ctrl_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        wait_mode = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, sck_o, sck_oe, mosi_o, mosi_oe;
   logic        miso_o, miso_oe, ss_n_o, ss_n_oe, sck_d, mosi_d, miso_d, ss_d;
   wire         sck_w = sck_oe ? sck_o : sck_d;
   wire         mosi_w = mosi_oe ? mosi_o : mosi_d;
   wire         miso_w = miso_oe ? miso_o : miso_d;
   wire         ss_w = ss_n_oe ? ss_n_o : ss_d;
   int          fails = 0;
   int          check_count = 0;
   int          cyc = 0;
   logic [7:0]  q;
   logic        e;

   // half period must cover the two-stage pin synchroniser plus one cycle
   spi_width_pin_ctrl #(.HALF_CNT(HALF_PERIOD_CYCLES)) spi_width_pin_ctrl_i (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sck_i(sck_w),
      .sck_o, .sck_oe, .mosi_i(mosi_w), .mosi_o, .mosi_oe, .miso_i(miso_w), .miso_o,
      .miso_oe, .ss_n_i(ss_w), .ss_n_o, .ss_n_oe, .wait_mode, .irq);
   spi_far_end spi_far_end_i (.sck_w, .mosi_w, .miso_w, .sck_d, .mosi_d, .miso_d, .ss_d);

   always #10 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////////
   // apb master: hold the request until pready is seen high
   task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // only the bench timeout ends this wait
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [9:0] idx, input logic [7:0] x, input string nm);
      apb(1'b0, idx, 8'h00);
      `CHK(nm, x, q)
   endtask

   task automatic mxfer(input logic [15:0] tx, input logic [15:0] rp, input int n);
      spi_far_end_i.load(rp, n);
      if (n == 16) apb(1'b1, IDX_DATA_HI, tx[15:8]);
      apb(1'b1, IDX_DATA_LO, tx[7:0]);
   endtask

   task automatic end_sim;
      if (fails == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         end_sim;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] tx, rp, got;
      logic [7:0]  frm [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
      logic [7:0]  to [5] = '{8'h40, 8'h10, 8'h01, 8'h09, 8'h02};
      logic [19:0] pins [8] = '{20'h50004, 20'h50010, 20'h50094, 20'h40010,
                                20'h40092, 20'h52105, 20'h52004, 20'h42110};
      logic [23:0] flt [3] = '{24'h500000, 24'h401000, 24'h501001};
      int          t;
      logic        s;
      void'($urandom(99326));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rchk(IDX_CTRL_TWO, CTRL_RESET, "ctrl2 reset");
      apb(1'b1, IDX_CTRL_TWO, 8'hff);
      rchk(IDX_CTRL_TWO, 8'hff & CTRL_TWO_BITS, "ctrl2 mask");
      apb(1'b0, 10'h002, 8'h00);
      `CHK("unmapped", 1'b1, e)
      // master frames, narrow then wide
      apb(1'b1, IDX_CTRL_ONE, 8'h50);
      for (int w = 0; w < 2; w++) begin
         tx = 16'($urandom);
         rp = 16'($urandom);
         apb(1'b1, IDX_CTRL_TWO, w ? 8'h40 : 8'h00);
         apb(1'b1, IDX_STATUS, 8'h90);
         mxfer(tx, rp, w ? 16 : 8);
         // the data write also returned a byte; do not let it end the poll
         q = 8'h00;
         for (int i = 0; i < 100 && q[BIT_DONE] !== 1'b1; i++) apb(1'b0, IDX_STATUS, 8'h00);
         `CHK("done", 1'b1, q[BIT_DONE])
         rchk(IDX_DATA_LO, rp[7:0], "rx low");
         rchk(IDX_DATA_HI, w ? rp[15:8] : 8'h00, "rx high");
         got = spi_far_end_i.rx_r & (w ? 16'hffff : 16'h00ff);
         `CHK("far rx", w ? tx : {8'h00, tx[7:0]}, got)
      end
      // control changes in mid-frame; only the wait bit, and the oe bit with pin control off, leave it running
      foreach (to[k]) begin
         apb(1'b1, IDX_CTRL_TWO, frm[k]);
         apb(1'b1, IDX_STATUS, 8'h90);
         mxfer(16'h00a5, 16'h005a, 8);
         apb(1'b1, IDX_CTRL_TWO, to[k]);
         repeat (100) @(posedge pclk);
         apb(1'b0, IDX_STATUS, 8'h00);
         `CHK("abort", k == 4, q[BIT_DONE])
      end
      foreach (pins[k]) begin
         // a slave drives its data pin only while selected
         spi_far_end_i.select(pins[k][16]);
         apb(1'b1, IDX_CTRL_ONE, pins[k][19:12]);
         apb(1'b1, IDX_CTRL_TWO, pins[k][11:4]);
         repeat (3) @(posedge pclk);
         `CHK("pin oe", pins[k][2:0], {mosi_oe, miso_oe, ss_n_oe})
         `CHK("sck oe", pins[k][16], sck_oe)
      end
      apb(1'b1, IDX_MASK, 8'h10);
      foreach (flt[k]) begin
         apb(1'b1, IDX_CTRL_ONE, flt[k][23:16]);
         apb(1'b1, IDX_CTRL_TWO, flt[k][15:8]);
         apb(1'b1, IDX_STATUS, 8'h90);
         spi_far_end_i.select(1'b0);
         repeat (8) @(posedge pclk);
         rchk(IDX_STATUS, {3'h0, flt[k][0], 4'h0}, "fault");
         `CHK("irq", flt[k][0], irq)
      end
      apb(1'b1, IDX_MASK, 8'h00);
      repeat (2) @(posedge pclk);
      `CHK("irq masked", 1'b0, irq)
      spi_far_end_i.select(1'b1);
      apb(1'b1, IDX_MASK, 8'h10);
      apb(1'b1, IDX_STATUS, 8'h10);
      rchk(IDX_STATUS, 8'h00, "w1c");
      `CHK("irq clear", 1'b0, irq)
      spi_far_end_i.select(1'b0);
      repeat (8) @(posedge pclk);
      apb(1'b1, IDX_CTRL_ONE, 8'h00);
      rchk(IDX_STATUS, 8'h00, "disable");
      spi_far_end_i.select(1'b1);
      // slave frame on the link clock
      tx = 16'($urandom);
      rp = 16'($urandom);
      apb(1'b1, IDX_CTRL_ONE, 8'h40);
      apb(1'b1, IDX_CTRL_TWO, 8'h00);
      apb(1'b1, IDX_DATA_LO, tx[7:0]);
      spi_far_end_i.xfer(rp, 8, got);
      `CHK("slave out", tx[7:0], got[7:0])
      rchk(IDX_DATA_LO, rp[7:0], "slave in");
      // wait mode with clock stop: no serial clock edges
      apb(1'b1, IDX_CTRL_ONE, 8'h50);
      apb(1'b1, IDX_CTRL_TWO, 8'h02);
      wait_mode <= 1'b1;
      repeat (4) @(posedge pclk);
      mxfer(16'h0033, 16'h0044, 8);
      t = 0;
      s = sck_o;
      for (int i = 0; i < 40; i++) begin
         @(posedge pclk);
         t += (sck_o !== s);
         s = sck_o;
      end
      `CHK("wait sck", 0, t)
      wait_mode <= 1'b0;
      end_sim;
   end
endmodule
